// ==== hdl/pio_channel.sv ====
// parallel io channel: 32 pads, request/reply register access, edge interrupts
`timescale 1ns/1ps

// Operation
// R1: thirty-two lines, each separately an output or a tristated input.
// R2: direction bit one enables pad driver; zero is input; reset all inputs.
// R3: output value register drives output pads, bit n to pad n, resets zero.
// R4: input sample register holds flip-flop captured pad values, resets zero.
// R5: source bit zero samples line on every rising system clock edge.
// R6: source bit one samples line on the external strobe pad instead.
// R7: strobe edge bit one captures on falling strobe edge, zero on rising.
// R8: strobe edge bit ignored while source bit is zero.
// R9: global interrupt gate at bit 0 disables all interrupts when zero; resets zero. An event already pending still leaves after the gate clears.
// R10: per-line mask lets only lines with bit one raise interrupts; resets zero.
// R11: polarity bit one triggers on rising transition, zero on falling; resets zero.
// R12: interrupt only with mask bit and gate set and selected edge occurring.
// R13: register writes act on pads and sampling immediately, no commit step.
// R14: every read or write request is answered with a reply packet.
// R15: whole channel can be disabled to save power; ch_enable_q stops only sampling and interrupts, pads stay driven.
// R16: host clears direction, gate and mask bits for input-only use.
// R17: host sets direction, writes output value, clears mask for output use.
// R18: interrupt sends unsolicited packet with id 0xFF carrying the event vector.
// R19: most recent interrupt vector kept in a readable vector register.
// R20: edges found by comparing consecutive samples; one transition gives one event.
module pio_channel (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic             req_valid,
   input  wire pio_pkg::pio_req_t req,
   output logic                  rep_valid,
   output pio_pkg::pio_rep_t     rep,
   input  wire logic [31:0]      pad_in,
   output logic      [31:0]      pad_out,
   output logic      [31:0]      pad_oe,
   input  wire logic             strobe_pad,
   output logic                  ch_active
);

   ////////////////////////////////////////////////////////////////////////////
   // configuration and state registers

   logic [31:0]       out_value_q;
   logic [31:0]       direction_q;
   logic [31:0]       sample_q;
   logic [31:0]       sample_d;
   logic [31:0]       prev_sample_q;
   logic [31:0]       irq_mask_q;
   logic [31:0]       irq_pol_q;
   logic [31:0]       src_sel_q;
   logic [31:0]       edge_sel_q;
   logic [31:0]       irq_vector_q;
   logic [31:0]       irq_pending_q;
   logic              irq_gate_q;
   logic              ch_enable_q;
   logic              rep_valid_q;
   pio_pkg::pio_rep_t rep_q;

   ////////////////////////////////////////////////////////////////////////////
   // pad and strobe synchronisers

   logic [31:0] pad_meta_q;
   logic [31:0] pad_sync_q;
   logic        strobe_meta_q;
   logic        strobe_sync_q;
   logic        strobe_prev_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pad_meta_q <= pio_pkg::RST_WORD;
         pad_sync_q <= pio_pkg::RST_WORD;
      end else begin
         pad_meta_q <= pad_in;
         pad_sync_q <= pad_meta_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         strobe_meta_q <= 1'h0;
         strobe_sync_q <= 1'h0;
         strobe_prev_q <= 1'h0;
      end else begin
         strobe_meta_q <= strobe_pad;
         strobe_sync_q <= strobe_meta_q;
         strobe_prev_q <= strobe_sync_q;
      end
   end

   // edges seen only after both data and strobe have passed two stages,
   // so pad data captured on a strobe edge is aligned with that edge
   wire strobe_rise = strobe_sync_q & ~strobe_prev_q;
   wire strobe_fall = ~strobe_sync_q & strobe_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // request decode

   wire       req_take   = req_valid;
   wire [7:0] cmd        = req.cmd;
   wire       wr_out     = req_take && (cmd == pio_pkg::CMD_W_OUT_VALUE);
   wire       wr_dir     = req_take && (cmd == pio_pkg::CMD_W_DIRECTION);
   wire       wr_mask    = req_take && (cmd == pio_pkg::CMD_W_IRQ_MASK);
   wire       wr_pol     = req_take && (cmd == pio_pkg::CMD_W_IRQ_POL);
   wire       wr_enable  = req_take && (cmd == pio_pkg::CMD_W_CH_ENABLE);
   wire       wr_gate    = req_take && (cmd == pio_pkg::CMD_W_IRQ_GATE);
   wire       wr_vector  = req_take && (cmd == pio_pkg::CMD_W_IRQ_VECTOR);
   wire       wr_src     = req_take && (cmd == pio_pkg::CMD_W_SRC_SEL);
   wire       wr_edge    = req_take && (cmd == pio_pkg::CMD_W_EDGE_SEL);
   wire       is_write   = wr_out | wr_dir | wr_mask | wr_pol | wr_enable | wr_gate | wr_vector | wr_src | wr_edge;

   // read decode: one hit per readable register, selected by an and-or tree
   wire        rd_out    = cmd == pio_pkg::CMD_R_OUT_VALUE;
   wire        rd_in     = cmd == pio_pkg::CMD_R_IN_SAMPLE;
   wire        rd_dir    = cmd == pio_pkg::CMD_R_DIRECTION;
   wire        rd_mask   = cmd == pio_pkg::CMD_R_IRQ_MASK;
   wire        rd_pol    = cmd == pio_pkg::CMD_R_IRQ_POL;
   wire        rd_enable = cmd == pio_pkg::CMD_R_CH_ENABLE;
   wire        rd_gate   = cmd == pio_pkg::CMD_R_IRQ_GATE;
   wire        rd_vector = cmd == pio_pkg::CMD_R_IRQ_VECTOR;
   wire        rd_src    = cmd == pio_pkg::CMD_R_SRC_SEL;
   wire        rd_edge   = cmd == pio_pkg::CMD_R_EDGE_SEL;
   wire        rd_hit    = rd_out | rd_in | rd_dir | rd_mask | rd_pol | rd_enable | rd_gate | rd_vector | rd_src
                         | rd_edge;
   // command codes are distinct, so at most one term is ever selected
   wire [31:0] rd_data   = ({32{rd_out}}    & out_value_q)
                         | ({32{rd_in}}     & sample_q)
                         | ({32{rd_dir}}    & direction_q)
                         | ({32{rd_mask}}   & irq_mask_q)
                         | ({32{rd_pol}}    & irq_pol_q)
                         | ({32{rd_enable}} & {31'h0000_0000, ch_enable_q})
                         | ({32{rd_gate}}   & {31'h0000_0000, irq_gate_q})
                         | ({32{rd_vector}} & irq_vector_q)
                         | ({32{rd_src}}    & src_sel_q)
                         | ({32{rd_edge}}   & edge_sel_q);

   wire is_read = req_take && rd_hit;

   ////////////////////////////////////////////////////////////////////////////
   // configuration writes, effective on the next edge

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         out_value_q <= pio_pkg::RST_WORD; // R3
      end else if (wr_out) begin
         out_value_q <= req.data; // R13
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         direction_q <= pio_pkg::RST_WORD; // R2
      end else if (wr_dir) begin
         direction_q <= req.data; // R13
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_mask_q <= pio_pkg::RST_WORD; // R10
      end else if (wr_mask) begin
         irq_mask_q <= req.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_pol_q <= pio_pkg::RST_WORD; // R11
      end else if (wr_pol) begin
         irq_pol_q <= req.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         src_sel_q <= pio_pkg::RST_WORD;
      end else if (wr_src) begin
         src_sel_q <= req.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         edge_sel_q <= pio_pkg::RST_WORD;
      end else if (wr_edge) begin
         edge_sel_q <= req.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_gate_q <= pio_pkg::RST_IRQ_GATE; // R9
      end else if (wr_gate) begin
         irq_gate_q <= req.data[pio_pkg::GATE_BIT]; // R9
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ch_enable_q <= pio_pkg::RST_CH_ENABLE;
      end else if (wr_enable) begin
         ch_enable_q <= req.data[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-line input capture

   logic [31:0] line_capture;

   genvar gi;
   generate
      for (gi = 0; gi < pio_pkg::LINES; gi++) begin : g_line
         // edge select only matters for strobe-sampled lines
         wire strobe_hit = edge_sel_q[gi] ? strobe_fall : strobe_rise; // R7
         wire take       = src_sel_q[gi] ? strobe_hit : 1'b1; // R5 R6 R8
         assign line_capture[gi] = ch_enable_q & take; // R15
         assign sample_d[gi]     = line_capture[gi] ? pad_sync_q[gi] : sample_q[gi];
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sample_q <= pio_pkg::RST_WORD; // R4
      end else begin
         sample_q <= sample_d; // R4
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prev_sample_q <= pio_pkg::RST_WORD;
      end else begin
         prev_sample_q <= sample_q; // R20
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt events

   // consecutive registered samples, so one transition is one event
   wire [31:0] rose      = sample_q & ~prev_sample_q; // R20
   wire [31:0] fell      = ~sample_q & prev_sample_q; // R20
   wire [31:0] edge_hit  = (irq_pol_q & rose) | (~irq_pol_q & fell); // R11
   wire        irq_allow = irq_gate_q & ch_enable_q; // R9 R15
   wire [31:0] irq_event = edge_hit & irq_mask_q & ~direction_q & {32{irq_allow}}; // R10 R12
   wire        irq_any   = |irq_event;

   ////////////////////////////////////////////////////////////////////////////
   // reply arbitration: request reply wins, interrupt waits in pending

   wire        req_reply   = req_take;
   wire [31:0] pending_all = irq_pending_q | irq_event;
   wire        send_irq    = ~req_reply && (|irq_pending_q);

   // hardware event wins over a host write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_vector_q <= pio_pkg::RST_WORD;
      end else if (irq_any) begin
         irq_vector_q <= irq_event; // R19
      end else if (wr_vector) begin
         irq_vector_q <= req.data;
      end
   end

   // an event arriving while the pending word leaves is kept, not lost
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_pending_q <= pio_pkg::RST_WORD;
      end else if (send_irq) begin
         irq_pending_q <= irq_event;
      end else begin
         irq_pending_q <= pending_all;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reply packet

   // send_irq is only ever high without a request, so the fields never mix
   wire        rep_fire  = req_reply | send_irq; // R14 R18
   wire        rep_bad   = req_reply & ~is_read & ~is_write;
   wire [7:0]  rep_trn_d = send_irq ? pio_pkg::IRQ_TRN_ID : req.trn; // R18
   wire [7:0]  rep_len_d = send_irq ? pio_pkg::LEN_IRQ_PACKET :
                           is_read  ? pio_pkg::LEN_READ_REPLY : pio_pkg::LEN_WRITE_REPLY;
   wire [7:0]  rep_err_d = rep_bad ? pio_pkg::ERR_BAD_COMMAND : pio_pkg::ERR_NONE;
   wire [31:0] rep_dat_d = send_irq ? irq_pending_q : // R18
                           is_read  ? rd_data : pio_pkg::RST_WORD;
   pio_pkg::pio_rep_t rep_d;
   assign rep_d = {rep_trn_d, rep_len_d, rep_err_d, rep_dat_d};

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rep_valid_q <= 1'h0;
      end else begin
         rep_valid_q <= rep_fire; // R14 R18
      end
   end

   // the packet stands between pulses, so a slow reader still sees the last one
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rep_q <= '0;
      end else if (rep_fire) begin
         rep_q <= rep_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   logic [31:0] pad_out_q;
   logic [31:0] pad_oe_q;
   logic        ch_active_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pad_out_q <= pio_pkg::RST_WORD;
      end else begin
         pad_out_q <= wr_out ? req.data : out_value_q; // R3 R13
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pad_oe_q <= pio_pkg::RST_WORD;
      end else begin
         pad_oe_q <= wr_dir ? req.data : direction_q; // R1 R2 R13
      end
   end

   // follows the enable register one edge late; reads low during reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ch_active_q <= 1'h0;
      end else begin
         ch_active_q <= ch_enable_q;
      end
   end

   assign pad_out   = pad_out_q;
   assign pad_oe    = pad_oe_q;
   assign rep_valid = rep_valid_q;
   assign rep       = rep_q;
   assign ch_active = ch_active_q;

endmodule

// ==== hdl/pio_pkg.sv ====
// package: constants and carrier types of the parallel io channel
package pio_pkg;

   localparam int unsigned LINES = 32;

   // request command codes
   localparam logic [7:0] CMD_W_OUT_VALUE  = 8'h10;
   localparam logic [7:0] CMD_R_OUT_VALUE  = 8'h11;
   localparam logic [7:0] CMD_R_IN_SAMPLE  = 8'h01;
   localparam logic [7:0] CMD_W_DIRECTION  = 8'h20;
   localparam logic [7:0] CMD_R_DIRECTION  = 8'h21;
   localparam logic [7:0] CMD_W_IRQ_MASK   = 8'h30;
   localparam logic [7:0] CMD_R_IRQ_MASK   = 8'h31;
   localparam logic [7:0] CMD_W_IRQ_POL    = 8'h40;
   localparam logic [7:0] CMD_R_IRQ_POL    = 8'h41;
   localparam logic [7:0] CMD_W_CH_ENABLE  = 8'h50;
   localparam logic [7:0] CMD_R_CH_ENABLE  = 8'h51;
   localparam logic [7:0] CMD_W_IRQ_GATE   = 8'h60;
   localparam logic [7:0] CMD_R_IRQ_GATE   = 8'h61;
   localparam logic [7:0] CMD_W_IRQ_VECTOR = 8'h70;
   localparam logic [7:0] CMD_R_IRQ_VECTOR = 8'h71;
   localparam logic [7:0] CMD_W_SRC_SEL    = 8'h80;
   localparam logic [7:0] CMD_R_SRC_SEL    = 8'h81;
   localparam logic [7:0] CMD_W_EDGE_SEL   = 8'h90;
   localparam logic [7:0] CMD_R_EDGE_SEL   = 8'h91;

   // reply fields
   localparam logic [7:0] IRQ_TRN_ID       = 8'hFF;
   localparam logic [7:0] LEN_WRITE_REPLY  = 8'h02;
   localparam logic [7:0] LEN_READ_REPLY   = 8'h04;
   localparam logic [7:0] LEN_IRQ_PACKET   = 8'h04;
   localparam logic [7:0] ERR_NONE         = 8'h00;
   localparam logic [7:0] ERR_BAD_COMMAND  = 8'h04;

   // reset values and the gate bit index
   localparam logic [31:0] RST_WORD        = 32'h0000_0000;
   localparam logic        RST_IRQ_GATE    = 1'h0;
   localparam logic        RST_CH_ENABLE   = 1'h1;
   localparam int unsigned GATE_BIT        = 0;

   typedef struct packed {
      logic [7:0]  trn;
      logic [7:0]  cmd;
      logic [31:0] data;
   } pio_req_t;

   typedef struct packed {
      logic [7:0]  trn;
      logic [7:0]  len;
      logic [7:0]  err;
      logic [31:0] data;
   } pio_rep_t;

endpackage

// ==== sim/pio_channel_sva.sv ====
// checker: port-level properties of the parallel io channel
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module pio_channel_sva (
   input wire logic              sys_clk,
   input wire logic              reset,
   input wire logic              req_valid,
   input wire pio_pkg::pio_req_t req,
   input wire logic              rep_valid,
   input wire pio_pkg::pio_rep_t rep,
   input wire logic [31:0]       pad_in,
   input wire logic [31:0]       pad_out,
   input wire logic [31:0]       pad_oe,
   input wire logic              strobe_pad,
   input wire logic              ch_active
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic       gate_q;
   logic [3:0] off_q;
   wire        wr_out = req_valid && req.cmd == pio_pkg::CMD_W_OUT_VALUE;
   // request-free cycles since the gate shut, saturating; a deferred event leaves in the first
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gate_q <= 1'h0;
         off_q  <= 4'h0;
      end else begin
         if (req_valid && req.cmd == pio_pkg::CMD_W_IRQ_GATE) gate_q <= req.data[0];
         off_q <= gate_q ? 4'h0 : off_q + {3'h0, (off_q != 4'hf) && !req_valid};
      end
   end
   property p_reply; req_valid |=> rep_valid && rep.trn == $past(req.trn); endproperty
   a_reply: assert property (p_reply) else $error("no reply");
   property p_out_wr; wr_out |=> pad_out == $past(req.data) && rep.len == pio_pkg::LEN_WRITE_REPLY; endproperty
   a_out_wr: assert property (p_out_wr) else $error("output write");
   property p_dir_wr; req_valid && req.cmd == pio_pkg::CMD_W_DIRECTION |=> pad_oe == $past(req.data); endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("direction write");
   property p_out_hold; !wr_out |=> $stable(pad_out); endproperty
   a_out_hold: assert property (p_out_hold) else $error("output moved");
   property p_rd_out; req_valid && req.cmd == pio_pkg::CMD_R_OUT_VALUE |=> rep.data == pad_out; endproperty
   a_rd_out: assert property (p_rd_out) else $error("output read");
   property p_irq_fmt;
      rep_valid && !$past(req_valid) |-> rep.trn == pio_pkg::IRQ_TRN_ID && rep.len == pio_pkg::LEN_IRQ_PACKET;
   endproperty
   a_irq_fmt: assert property (p_irq_fmt) else $error("event packet");
   property p_rst; $fell(reset) |-> !rep_valid && pad_out == pio_pkg::RST_WORD && pad_oe == 32'h0000_0000; endproperty
   a_rst: assert property (p_rst) else $error("reset values");
   property p_gate_off; rep_valid && !$past(req_valid) |-> off_q < 4'h2; endproperty
   a_gate_off: assert property (p_gate_off) else $error("packet while gated");
endmodule
bind pio_channel pio_channel_sva u_sva (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req),
   .rep_valid(rep_valid), .rep(rep), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .strobe_pad(strobe_pad), .ch_active(ch_active));

// ==== sim/pio_channel_tb.sv ====
// self-checking bench of the parallel io channel
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module pio_channel_tb;
   logic              sys_clk    = 1'h0;
   logic              reset      = 1'h1;
   logic              req_valid  = 1'h0;
   pio_pkg::pio_req_t req        = '0;
   pio_pkg::pio_rep_t rep;
   pio_pkg::pio_rep_t exp_q[$];
   logic              rep_valid, strobe_pad, ch_active;
   logic [31:0]       pad_in, pad_out, pad_oe, v;
   logic [31:0]       app        = 32'h0000_0000;
   int                num_errors = 0;
   int                checks     = 0;
   logic [7:0]        wc[7]      = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h70, 8'h80, 8'h90};
   logic [7:0]        bc[3]      = '{8'h00, 8'h0e, 8'ha1};
   pio_channel DUT (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req), .rep_valid(rep_valid),
      .rep(rep), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .strobe_pad(strobe_pad), .ch_active(ch_active));
   pio_pads_model u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .app_val(app), .pad_in(pad_in), .strobe_pad(strobe_pad));
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic cmp(input logic [55:0] seen, input logic [55:0] expv);
      checks++;
      if (seen !== expv) begin
         num_errors++;
         $display("Error %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // valid stays up across back-to-back calls; cyc lowers it
   task automatic op(input logic [7:0] c, input logic [31:0] d = 32'h0000_0000, input logic [31:0] e = 32'h0000_0000);
      logic rd;
      logic bad;
      bad = c == 8'h00 || c[3:1] != 3'h0 || c[7:4] > 4'h9;
      rd = c[0] && !bad;
      @(negedge sys_clk);
      req_valid = 1'h1;
      req = '{8'($urandom_range(0, 254)), c, d};
      exp_q.push_back('{req.trn, rd ? pio_pkg::LEN_READ_REPLY : pio_pkg::LEN_WRITE_REPLY,
                        bad ? pio_pkg::ERR_BAD_COMMAND : pio_pkg::ERR_NONE, rd ? e : 32'h0000_0000});
   endtask
   task automatic cyc(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         req_valid = 1'h0;
      end
   endtask
   task automatic stb();
      cyc(1);
      u_pads.tog();
   endtask
   always @(negedge sys_clk) begin
      if (rep_valid === 1'h1) begin
         if (exp_q.size() == 0) cmp(rep, '1);
         else cmp(rep, exp_q.pop_front());
      end
   end
   initial begin
      v = $urandom(30315);
      repeat (10) @(negedge sys_clk);
      reset = 1'h0;
      foreach (wc[i]) op(wc[i] + 8'h01, 32'h0000_0000, pio_pkg::RST_WORD);
      op(pio_pkg::CMD_R_IN_SAMPLE);
      op(pio_pkg::CMD_R_IRQ_GATE, 32'h0000_0000, 32'(pio_pkg::RST_IRQ_GATE));
      op(pio_pkg::CMD_R_CH_ENABLE, 32'h0000_0000, 32'(pio_pkg::RST_CH_ENABLE));
      foreach (bc[i]) op(bc[i], $urandom);
      foreach (wc[i]) begin
         v = $urandom;
         op(wc[i], v);
         op(wc[i] + 8'h01, 32'h0000_0000, v);
      end
      op(pio_pkg::CMD_W_IRQ_MASK);
      op(pio_pkg::CMD_W_SRC_SEL);
      op(pio_pkg::CMD_W_EDGE_SEL, 32'hffff_ffff);
      op(pio_pkg::CMD_W_DIRECTION, 32'hffff_0000);
      op(pio_pkg::CMD_W_OUT_VALUE, v);
      app = $urandom;
      cyc(6);
      cmp(56'(pad_oe), 56'(32'hffff_0000));
      op(pio_pkg::CMD_R_IN_SAMPLE, 32'h0000_0000, (v & 32'hffff_0000) | (app & 32'h0000_ffff));
      op(pio_pkg::CMD_W_DIRECTION);
      op(pio_pkg::CMD_W_SRC_SEL, 32'hffff_ffff);
      op(pio_pkg::CMD_W_EDGE_SEL);
      cyc(6);
      app = $urandom;
      v = app;
      stb();
      cyc(1);
      app = ~v;
      stb();
      op(pio_pkg::CMD_R_IN_SAMPLE, 32'h0000_0000, v);
      op(pio_pkg::CMD_W_EDGE_SEL, 32'hffff_ffff);
      stb();
      op(pio_pkg::CMD_R_IN_SAMPLE, 32'h0000_0000, v);
      stb();
      op(pio_pkg::CMD_R_IN_SAMPLE, 32'h0000_0000, ~v);
      op(pio_pkg::CMD_W_SRC_SEL);
      op(pio_pkg::CMD_W_CH_ENABLE);
      cyc(6);
      app = v;
      cyc(6);
      cmp(56'(ch_active), 56'h0);
      op(pio_pkg::CMD_R_IN_SAMPLE, 32'h0000_0000, ~v);
      op(pio_pkg::CMD_W_CH_ENABLE, 32'h0000_0001);
      cyc(6);
      cmp(56'(ch_active), 56'h1);
      op(pio_pkg::CMD_R_IN_SAMPLE, 32'h0000_0000, v);
      cyc(1);
      app = 32'h0000_0004;
      cyc(6);
      op(pio_pkg::CMD_W_IRQ_POL, 32'h0000_0001);
      op(pio_pkg::CMD_W_IRQ_MASK, 32'h0000_0005);
      op(pio_pkg::CMD_W_IRQ_GATE, 32'h0000_0001);
      cyc(4);
      exp_q.push_back('{pio_pkg::IRQ_TRN_ID, pio_pkg::LEN_IRQ_PACKET, pio_pkg::ERR_NONE, 32'h0000_0005});
      app = 32'h0000_0003;
      cyc(10);
      op(pio_pkg::CMD_R_IRQ_VECTOR, 32'h0000_0000, 32'h0000_0005);
      cyc(1);
      app = 32'h0000_0007;
      cyc(10);
      op(pio_pkg::CMD_W_IRQ_GATE);
      cyc(2);
      app = 32'h0000_0002;
      cyc(10);
      op(pio_pkg::CMD_W_IRQ_GATE, 32'h0000_0001);
      op(pio_pkg::CMD_W_IRQ_MASK);
      cyc(2);
      app = 32'h0000_0007;
      cyc(10);
      if (exp_q.size() != 0) num_errors++;
      finish_test();
   end
endmodule

// ==== sim/pio_pads_model.sv ====
// pad-side application model: input levels and the strobe pad
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module pio_pads_model (
   input  wire logic [31:0] pad_out,
   input  wire logic [31:0] pad_oe,
   input  wire logic [31:0] app_val,
   output logic      [31:0] pad_in,
   output logic             strobe_pad
);
   // driven pads show the channel's level, the others the application's
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & app_val);
   initial strobe_pad = 1'h0;
   // half of a 125 ns period; the strobe stands still between calls
   task automatic tog();
      #1.3 strobe_pad = ~strobe_pad;
      #61.2;
   endtask
endmodule
